// ==== logic/cfg_pkg.sv ====
// Constants for the serial configuration and interrupt status block.
package cfg_pkg;
    localparam int          FRAME_BITS    = 24;
    localparam int          INST_BITS     = 16;
    localparam int          SNAP_W        = 40;
    localparam logic [12:0] OFS_SETUP     = 13'h0000;
    localparam logic [12:0] OFS_CLIP      = 13'h0001;
    localparam logic [12:0] OFS_PARITY    = 13'h0002;
    localparam logic [12:0] OFS_MASK      = 13'h0003;
    localparam logic [12:0] OFS_PEND      = 13'h0004;
    localparam int          INST_RD_BIT   = 15;
    localparam int          SETUP_DIR     = 7;
    localparam int          SETUP_ORDER   = 6;
    localparam int          SETUP_SRST    = 5;
    localparam int          SETUP_LONG    = 4;
    localparam logic [7:0]  SETUP_RST     = 8'h18;
    localparam logic [7:0]  MASK_RST      = 8'h00;
    localparam logic [7:0]  SRC_MASK      = 8'hfe;
    localparam int          EV_PARITY     = 7;
    localparam int          EV_SELFTEST   = 6;
    localparam int          EV_PSET       = 5;
    localparam int          EV_PCLR       = 4;
    localparam int          EV_LOCKED     = 3;
    localparam int          EV_UNLOCKED   = 2;
    localparam int          EV_OVERFLOW   = 1;
endpackage : cfg_pkg

// ==== logic/serial_config_and_irq_status.sv ====
// Serial configuration port, fault counters and interrupt pending logic.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Setup bit 7 low keeps data pin input only; high makes it bidirectional.
// - Setup bit 6 low sends most significant bit first; high least first.
// - Writing setup bit 5 resets the device; the bit clears itself next cycle.
// - Read-only 8-bit counter of clipped samples after the summing node gain.
// - Writing one to status bit 1 clears the clip counter.
// - Read-only 8-bit counter of input parity faults.
// - Writing one to status bit 7 clears the parity fault counter.
// - Enable bits 7 to 1 let their events raise requests; bit 0 reserved.
// - An enabled event sets its status bit and pulls the interrupt pin low.
// - Status bit 7 flags parity faults; writing one clears it.
// - Status bit 6 flags self-test finished; writing one clears it.
// - Status bit 5 flags parameter update set; writing one clears it.
// - Status bit 4 flags parameter update cleared; writing one clears it.
// - Status bit 3 reads one while core handoff is locked; no clear.
// - Status bit 2 flags handoff lost; writing one clears it.
// - Status bit 1 flags interpolator overflow; writing one clears it.
module serial_config_and_irq_status
    import cfg_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic sdio_i,
    output logic      sdio_o,
    output logic      sdio_oe_n,
    output logic      sdo,
    output logic      irq_n,
    output logic      soft_reset,
    input  wire logic clip_sample,
    input  wire logic parity_fault,
    input  wire logic selftest_finished,
    input  wire logic param_update_set,
    input  wire logic param_update_cleared,
    input  wire logic handoff_locked,
    input  wire logic handoff_unlocked,
    input  wire logic overflow_fault
);
    // ****************************************************************
    // Link side, clocked by the serial clock.
    // ****************************************************************
    // Idle chip select holds the bit counter and the output flops in reset, so each frame starts at bit zero.
    logic [4:0]        cnt_q, cnt_d;
    logic [23:0]       sr_q, sr_d;
    logic [15:0]       inst_q, inst_d;
    logic [7:0]        wdat_q, wdat_d;
    logic              wval_q, wval_d;
    logic              out_q, out_d;
    logic              oe_n_q, oe_n_d;
    logic              sdo_q, sdo_d;
    logic [SNAP_W-1:0] snap_q, snap_d;
    logic              lsb_first, dir_bidir, rd_phase;
    logic [7:0]        rd_byte;
    logic [12:0]       link_addr;
    logic [15:0]       wrev;

    // Reverses a half word for the least significant bit first order.
    function automatic logic [15:0] rev16(input logic [15:0] v);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15-i];
        end
        return r;
    endfunction : rev16

    assign lsb_first = snap_q[SETUP_ORDER];
    assign dir_bidir = snap_q[SETUP_DIR];
    assign link_addr = inst_q[12:0];
    // Read data only leaves during the eight data bits of a read frame.
    assign rd_phase  = inst_q[INST_RD_BIT] && (cnt_q >= 5'(INST_BITS))
                       && (cnt_q < 5'(FRAME_BITS));

    always_comb begin
        unique case (link_addr)
            OFS_SETUP:  rd_byte = snap_q[7:0];
            OFS_CLIP:   rd_byte = snap_q[15:8];
            OFS_PARITY: rd_byte = snap_q[23:16];
            OFS_MASK:   rd_byte = snap_q[31:24];
            OFS_PEND:   rd_byte = snap_q[39:32];
            default:    rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        cnt_d  = (cnt_q < 5'(FRAME_BITS)) ? cnt_q + 5'h01 : cnt_q;
        sr_d   = {sr_q[22:0], sdio_i};
        // The byte sits in the upper half after reversal, so a part-select picks it.
        wrev   = rev16({8'h00, sr_d[7:0]});
        inst_d = inst_q;
        wdat_d = wdat_q;
        wval_d = wval_q;
        if (cnt_q == 5'h00) begin
            wval_d = 1'b0;
        end
        // The instruction lands after its sixteenth bit, the data byte after the last.
        if (cnt_q == 5'(INST_BITS - 1)) begin
            inst_d = lsb_first ? rev16(sr_d[15:0]) : sr_d[15:0];
        end
        if (cnt_q == 5'(FRAME_BITS - 1)) begin
            wdat_d = lsb_first ? wrev[15:8] : sr_d[7:0];
            wval_d = !inst_q[INST_RD_BIT];
        end
    end

    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            cnt_q <= 5'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge sclk) begin
        sr_q   <= sr_d;
        inst_q <= inst_d;
        wdat_q <= wdat_d;
        wval_q <= wval_d;
    end

    // Read data leaves on the falling edge so the host samples it on the rising one.
    always_comb begin
        out_d  = lsb_first ? rd_byte[cnt_q[2:0]] : rd_byte[3'h7 - cnt_q[2:0]];
        oe_n_d = !(rd_phase && dir_bidir);
        sdo_d  = rd_phase && !dir_bidir && out_d;
    end

    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            out_q  <= 1'b0;
            oe_n_q <= 1'b1;
            sdo_q  <= 1'b0;
        end else begin
            out_q  <= out_d;
            oe_n_q <= oe_n_d;
            sdo_q  <= sdo_d;
        end
    end

    assign sdio_o    = out_q;
    assign sdio_oe_n = oe_n_q;
    assign sdo       = sdo_q;

    // ****************************************************************
    // Register side, clocked by the reference clock.
    // ****************************************************************
    logic             cs_s1_q, cs_s2_q, cs_s3_q;
    logic [7:0]       setup_q, setup_d;
    logic [CNT_W-1:0] clip_q, clip_d, par_q, par_d;
    logic [7:0]       mask_q, mask_d;
    logic [7:0]       pend_q, pend_d;
    logic             irq_n_q, irq_n_d;
    logic             srst_q, srst_d;
    logic             commit;
    logic [7:0]       events, w1c;

    // The write word is quiet while chip select is high; the synced edge qualifies it.
    assign commit = cs_s2_q && !cs_s3_q && wval_q;
    assign w1c    = (commit && link_addr == OFS_PEND) ? wdat_q : 8'h00;
    // Bit 0 is reserved and bit 3 is a live level, so neither enters the sticky set.
    assign events = {parity_fault, selftest_finished, param_update_set,
                     param_update_cleared, 1'b0, handoff_unlocked, overflow_fault, 1'b0};

    always_comb begin
        setup_d = setup_q;
        mask_d  = mask_q;
        srst_d  = 1'b0;
        clip_d  = clip_q;
        par_d   = par_q;
        if (commit && link_addr == OFS_SETUP) begin
            setup_d = wdat_q;
            srst_d  = wdat_q[SETUP_SRST];
        end
        if (commit && link_addr == OFS_MASK) begin
            mask_d = wdat_q & SRC_MASK;
        end
        if (w1c[EV_OVERFLOW]) begin
            clip_d = '0;
        end
        if (clip_sample && clip_d != '1) begin
            clip_d = clip_d + 1'b1;
        end
        if (w1c[EV_PARITY]) begin
            par_d = '0;
        end
        if (parity_fault && par_d != '1) begin
            par_d = par_d + 1'b1;
        end
        // A source that fires in the cycle of its clear stays pending.
        pend_d = pend_q & ~w1c & SRC_MASK;
        pend_d = pend_d | (events & mask_q & SRC_MASK);
        pend_d[EV_LOCKED] = handoff_locked && mask_q[EV_LOCKED];
        // The pin follows the pending flags one cycle late, from a plain flop.
        irq_n_d = !(|(pend_q & mask_q));
        // The snapshot follows the registers only while the frame select is idle,
        // so the link logic reads a word that stands still for the whole frame.
        snap_d  = cs_s2_q ? {pend_q, mask_q, par_q, clip_q, setup_q} : snap_q;
    end

    always_ff @(posedge ref_clk) begin
        // Two stages settle the frame select; the third shows its rising edge.
        cs_s1_q <= cs_n;
        cs_s2_q <= cs_s1_q;
        cs_s3_q <= cs_s2_q;
        if (!rst_n || srst_q) begin
            setup_q <= SETUP_RST;
            mask_q  <= MASK_RST;
            clip_q  <= '0;
            par_q   <= '0;
            pend_q  <= 8'h00;
            irq_n_q <= 1'b1;
            srst_q  <= 1'b0;
            snap_q  <= '0;
        end else begin
            setup_q <= setup_d;
            mask_q  <= mask_d;
            clip_q  <= clip_d;
            par_q   <= par_d;
            pend_q  <= pend_d;
            irq_n_q <= irq_n_d;
            srst_q  <= srst_d;
            snap_q  <= snap_d;
        end
    end

    assign irq_n      = irq_n_q;
    assign soft_reset = srst_q;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Most checks skip the self reset cycle, which clears every flag at once.
    chk_irq_raise: assert property (parity_fault && mask_q[EV_PARITY] && !srst_q
        |=> ##1 !irq_n) else $error("enabled event did not pull interrupt low");
    chk_irq_release: assert property (((pend_q & mask_q) == 8'h00) && !srst_q
        |=> irq_n) else $error("interrupt stayed low with nothing pending");
    chk_parity_w1c: assert property (w1c[EV_PARITY] && !parity_fault && !srst_q
        |=> !pend_q[EV_PARITY] && par_q == '0) else $error("parity clear failed");
    chk_clip_clear: assert property (w1c[EV_OVERFLOW] && !clip_sample && !srst_q
        |=> clip_q == '0) else $error("clip counter not cleared");
    chk_clip_count: assert property (clip_sample && !w1c[EV_OVERFLOW] && clip_q != '1
        && !srst_q |=> clip_q == $past(clip_q) + 1'b1) else $error("clip count missed");
    chk_soft_reset: assert property (commit && link_addr == OFS_SETUP
        && wdat_q[SETUP_SRST] |=> srst_q ##1 (!setup_q[SETUP_SRST] && !srst_q && pend_q == 8'h00))
        else $error("soft reset did not act and clear");
    chk_lock_level: assert property (handoff_locked && mask_q[EV_LOCKED] && !srst_q
        |=> pend_q[EV_LOCKED]) else $error("lock status not shown");
    chk_mask_gate: assert property (!mask_q[EV_OVERFLOW] && !pend_q[EV_OVERFLOW] && !srst_q
        |=> !pend_q[EV_OVERFLOW]) else $error("masked source set pending");
    chk_unlock_set: assert property (handoff_unlocked && mask_q[EV_UNLOCKED] && !srst_q
        |=> pend_q[EV_UNLOCKED]) else $error("unlock lost");

    // A clear and a new event in one cycle must leave the flag and one count.
    chk_set_wins: assert property (w1c[EV_PARITY] && parity_fault && mask_q[EV_PARITY]
        && !srst_q |=> pend_q[EV_PARITY] && par_q == CNT_W'(1))
        else $error("event lost against its clear");
    chk_par_count: assert property (parity_fault && !w1c[EV_PARITY] && par_q != '1
        && !srst_q |=> par_q == $past(par_q) + 1'b1)
        else $error("parity count missed");
    // Counters stick at full scale instead of wrapping back to a small value.
    chk_clip_hold: assert property (clip_q == '1 && !w1c[EV_OVERFLOW] && !srst_q
        |=> clip_q == '1)
        else $error("clip counter wrapped");
    chk_mask_write: assert property (commit && link_addr == OFS_MASK && !srst_q
        |=> !mask_q[0] && mask_q[7:1] == $past(wdat_q[7:1]))
        else $error("mask write not taken");
    chk_setup_write: assert property (commit && link_addr == OFS_SETUP
        && !wdat_q[SETUP_SRST] && !srst_q |=> setup_q == $past(wdat_q))
        else $error("setup write not taken");
    chk_unlock_hold: assert property (pend_q[EV_UNLOCKED] && !w1c[EV_UNLOCKED]
        && !srst_q |=> pend_q[EV_UNLOCKED])
        else $error("unlock flag dropped without clear");
    chk_unlock_w1c: assert property (w1c[EV_UNLOCKED] && !handoff_unlocked && !srst_q
        |=> !pend_q[EV_UNLOCKED])
        else $error("unlock flag not cleared");
    chk_lock_clear: assert property (!handoff_locked && !srst_q
        |=> !pend_q[EV_LOCKED])
        else $error("lock status stayed after lock went away");
    chk_srst_pulse: assert property (srst_q
        |=> !srst_q)
        else $error("soft reset held longer than one cycle");

    // ****************************************************************
    // Coverage of the main scenarios.
    // ****************************************************************
    cov_irq_cycle: cover property (!irq_n ##[1:50] irq_n);
    cov_write_mask: cover property (commit && link_addr == OFS_MASK);
    cov_set_vs_clear: cover property (w1c[EV_PARITY] && parity_fault);
    cov_soft_reset: cover property (srst_q);
    cov_clip_full: cover property (clip_sample && clip_q == '1);
endmodule : serial_config_and_irq_status

`default_nettype wire

// ==== logic/snap_fix_note.sv ====
// Holds no code; all logic of the block sits in one design file.

// ==== verif/host_model.sv ====
// Host side serial bus master model that runs one frame per call.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    output logic      sclk,
    output logic      cs_n,
    output wire logic sdio_i,
    input  wire logic sdio_o,
    input  wire logic sdio_oe_n,
    input  wire logic sdo
);
    logic hd;
    // The device wins the wire while it drives; a released host shows changing data.
    assign sdio_i = sdio_oe_n ? hd : sdio_o;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        hd   = 1'b0;
    end
    task automatic xfer(input logic lsb, input logic bi, input logic rd, input logic [12:0] adr,
                        input logic [7:0] wd, output logic [7:0] rv, output logic oe);
        logic [15:0] ins;
        logic        b;
        ins = {rd, 2'b00, adr};
        rv  = 8'h00;
        oe  = 1'b0;
        cs_n = 1'b0;
        #40;
        for (int i = 0; i < 24; i++) begin
            if (i < 16) hd = lsb ? ins[i] : ins[15-i];
            else if (!rd) hd = lsb ? wd[i-16] : wd[23-i];
            else hd = ~hd;
            #6;
            // Mode 0: read data is taken just before the rising edge it is meant for.
            if (!sdio_oe_n) oe = 1'b1;
            b = bi ? sdio_i : sdo;
            if (i >= 16) begin
                if (lsb) rv[i-16] = b;
                else rv[23-i] = b;
            end
            sclk = 1'b1;
            #6 sclk = 1'b0;
            #3;
        end
        #3 cs_n = 1'b1;
        #80;
    endtask : xfer
endmodule : host_model
`default_nettype wire

// ==== verif/tb_serial_config_and_irq_status.sv ====
// Self-checking bench for the serial configuration and interrupt status block.
`timescale 1ns/1ps
`default_nettype none
module tb_serial_config_and_irq_status;
    import cfg_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, lock = 1'b0, lsb_q = 1'b0, bi_q = 1'b0, srst_seen = 1'b0;
    logic [7:0] evt = 8'h00;
    wire logic  sclk, cs_n, sdio_i, sdio_o, sdio_oe_n, sdo, irq_n, soft_reset;
    int fails = 0, checked = 0;
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (soft_reset === 1'b1) srst_seen <= 1'b1;
    host_model host (.sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i), .sdio_o(sdio_o),
                     .sdio_oe_n(sdio_oe_n), .sdo(sdo));
    serial_config_and_irq_status dut (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk),
        .cs_n(cs_n), .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_n(sdio_oe_n), .sdo(sdo),
        .irq_n(irq_n), .soft_reset(soft_reset), .clip_sample(evt[0]), .parity_fault(evt[7]),
        .selftest_finished(evt[6]), .param_update_set(evt[5]), .param_update_cleared(evt[4]),
        .handoff_locked(lock), .handoff_unlocked(evt[2]), .overflow_fault(evt[1]));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_sim();
        if (fails == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic       o;
        host.xfer(lsb_q, bi_q, 1'b0, a, d, r, o);
    endtask : wr
    task automatic rd(input logic [12:0] a, input logic [7:0] e);
        logic [7:0] r;
        logic       o;
        host.xfer(lsb_q, bi_q, 1'b1, a, 8'h00, r, o);
        chk(r, e);
        chk({7'h00, o}, {7'h00, bi_q});
    endtask : rd
    task automatic ev(input int b);
        @(posedge ref_clk) evt[b] <= 1'b1;
        @(posedge ref_clk) evt[b] <= 1'b0;
    endtask : ev
    task automatic irq(input logic e);
        repeat (3) @(posedge ref_clk);
        #1 chk({7'h00, irq_n}, {7'h00, e});
    endtask : irq
    initial begin
        #200000;
        fails++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(OFS_SETUP, 8'h18);
        rd(OFS_MASK, 8'h00);
        rd(OFS_CLIP, 8'h00);
        rd(OFS_PEND, 8'h00);
        rd(13'h0005, 8'h00);
        ev(1);
        irq(1'b1);
        rd(OFS_PEND, 8'h00);
        wr(OFS_MASK, 8'hfe);
        for (int b = 7; b >= 1; b--) begin
            if (b == 3) @(posedge ref_clk) lock <= 1'b1;
            else ev(b);
            irq(1'b0);
            rd(OFS_PEND, 8'h01 << b);
            if (b == 7) rd(OFS_PARITY, 8'h01);
            wr(OFS_PEND, 8'h01 << b);
            if (b == 3) begin
                rd(OFS_PEND, 8'h08);
                @(posedge ref_clk) lock <= 1'b0;
                repeat (3) @(posedge ref_clk);
            end
            if (b == 7) rd(OFS_PARITY, 8'h00);
            rd(OFS_PEND, 8'h00);
            irq(1'b1);
        end
        repeat (3) ev(0);
        rd(OFS_CLIP, 8'h03);
        wr(OFS_CLIP, 8'h55);
        rd(OFS_CLIP, 8'h03);
        repeat (256) ev(0);
        rd(OFS_CLIP, 8'hff);
        wr(OFS_PEND, 8'h02);
        rd(OFS_CLIP, 8'h00);
        @(posedge ref_clk) evt[7] <= 1'b1;
        wr(OFS_PEND, 8'h80);
        @(posedge ref_clk) evt[7] <= 1'b0;
        rd(OFS_PEND, 8'h80);
        wr(OFS_PEND, 8'h80);
        rd(OFS_PEND, 8'h00);
        rd(OFS_PARITY, 8'h00);
        wr(OFS_SETUP, 8'h5a);
        lsb_q = 1'b1;
        rd(OFS_SETUP, 8'h5a);
        wr(OFS_SETUP, 8'hdb);
        bi_q = 1'b1;
        rd(OFS_SETUP, 8'hdb);
        wr(OFS_SETUP, 8'hff);
        chk({7'h00, srst_seen}, 8'h01);
        lsb_q = 1'b0;
        bi_q  = 1'b0;
        rd(OFS_SETUP, 8'h18);
        rd(OFS_MASK, 8'h00);
        end_sim();
    end
endmodule : tb_serial_config_and_irq_status
`default_nettype wire
